// ---- hw/flc_host.sv ----
// Purpose: Host controller that issues flash command sequences from AHB-Lite registers.
// Assumes: One flash device on the pins, one AHB-Lite master, single word transfers.
// Notes: Reads take one wait state, writes none; every response is OKAY.
// How it works
// R1: Array-read op writes code FF so later reads return memory data.
// R2: Program sends 40, then a second write with target address and data.
// R3: Program's first write may be 40 or 10, chosen by a command bit.
// R4: After a program, reads return status until array-read is issued.
// R5: Erase set-up followed by a non-confirm write makes the device flag errors.
// R6: Erase confirm right after set-up latches block address and starts erasing.
// R7: During a job the device only honours status read and suspend.
// R8: Code D0 while suspended resumes the suspended job.
// R9: D0 after lock set-up unlocks the block unless it is locked down.
// R10: Code B0 starts suspending; ready plus suspend flag report completion.
// R11: Suspended machine idles; driving reset/power-down low shuts everything down.
// R12: Code 70 selects status read regardless of address.
// R13: Device enters status read on its own once a job starts.
// R14: Lock, voltage, program and erase error flags are sticky in the device.
// R15: Code 50 clears the four sticky flags; driving reset/power-down low also clears them.
// R16: Code 90 selects identifier read of maker, part and lock codes.
// R17: Lock set-up followed by a non-lock code makes the device flag errors.
// R18: Code 01 after lock set-up locks the addressed block.
// R19: Code 2F after lock set-up locks down the addressed block.
// R20: Code 98 selects query mode returning interface parameters.
// R21: C0 then address and data programs protection; status reads follow.
// R22: Status bit 7 high means the write state machine is ready.
// R23: While program is suspended, only reads, status, ident, query, resume are sent.
// R24: Erase confirm carries D0 with an address inside the block.
// R25: Commands are taken on the rising write strobe; only the low byte counts.
`timescale 1ns/1ps
module flc_host (
   input wire logic clock_in, // System clock, 40 MHz.
   input wire logic rst_in, // Asynchronous reset, active high.
   input wire logic hsel_in, // AHB slave select.
   input wire logic [31:0] haddr_in, // AHB address.
   input wire logic [1:0] htrans_in, // AHB transfer type.
   input wire logic hwrite_in, // AHB write.
   input wire logic [2:0] hsize_in, // AHB size, word only.
   input wire logic [31:0] hwdata_in, // AHB write data.
   input wire logic hready_in, // AHB bus ready.
   input wire logic [15:0] dq_in, // Flash data pins in.
   output logic hreadyout_out, // AHB slave ready.
   output logic hresp_out, // AHB response, always OKAY.
   output logic [31:0] hrdata_out, // AHB read data.
   output flc_pkg::flc_pins_t flash_out, // Flash control, address and data drive.
   output logic reset_powerdown_n_out // Flash reset/power-down, active low.
);
   typedef enum logic [1:0] {
      S_IDLE = 2'b00, S_FIRST = 2'b01, S_SECOND = 2'b10
   } flc_seq_t;

   function automatic logic [7:0] first_code(input flc_pkg::flc_op_t op, input logic alt);
      unique case (op)
         flc_pkg::OP_ARRAY: first_code = flc_pkg::CODE_ARRAY; // R1
         flc_pkg::OP_STATUS: first_code = flc_pkg::CODE_STATUS;
         flc_pkg::OP_IDENT: first_code = flc_pkg::CODE_IDENT;
         flc_pkg::OP_QUERY: first_code = flc_pkg::CODE_QUERY;
         flc_pkg::OP_CLEAR: first_code = flc_pkg::CODE_CLEAR; // R15
         flc_pkg::OP_PROGRAM: first_code = alt ? flc_pkg::CODE_PROG_ALT : flc_pkg::CODE_PROG; // R3
         flc_pkg::OP_ERASE: first_code = flc_pkg::CODE_ERASE;
         flc_pkg::OP_SUSPEND: first_code = flc_pkg::CODE_SUSPEND;
         flc_pkg::OP_RESUME: first_code = flc_pkg::CODE_CONFIRM;
         flc_pkg::OP_PROT: first_code = flc_pkg::CODE_PROT; // R21
         default: first_code = flc_pkg::CODE_LOCK_SETUP;
      endcase
   endfunction : first_code

   function automatic logic two_cycle(input flc_pkg::flc_op_t op);
      two_cycle = op inside {flc_pkg::OP_PROGRAM, flc_pkg::OP_ERASE, flc_pkg::OP_LOCK,
                             flc_pkg::OP_UNLOCK, flc_pkg::OP_LOCKDOWN, flc_pkg::OP_PROT};
   endfunction : two_cycle

   function automatic logic [15:0] second_word(input flc_pkg::flc_op_t op,
                                               input logic [15:0] data);
      unique case (op)
         flc_pkg::OP_ERASE: second_word = {8'h00, flc_pkg::CODE_CONFIRM}; // R24
         flc_pkg::OP_LOCK: second_word = {8'h00, flc_pkg::CODE_LOCK};
         flc_pkg::OP_UNLOCK: second_word = {8'h00, flc_pkg::CODE_CONFIRM};
         flc_pkg::OP_LOCKDOWN: second_word = {8'h00, flc_pkg::CODE_LOCKDOWN};
         default: second_word = data; // R2
      endcase
   endfunction : second_word

   flc_seq_t state, next_state;
   flc_pkg::flc_op_t cur_op, next_cur_op;
   flc_pkg::flc_mode_t mode, next_mode;
   logic [flc_pkg::ADDR_W-1:0] reg_addr, next_reg_addr;
   logic [15:0] reg_data, next_reg_data;
   logic reg_ctrl, next_reg_ctrl;
   logic refused, next_refused;
   logic psusp, next_psusp, esusp, next_esusp;
   logic job_prog, next_job_prog;
   logic cyc_start, next_cyc_start, cyc_write, next_cyc_write;
   logic [flc_pkg::ADDR_W-1:0] cyc_addr, next_cyc_addr;
   logic [15:0] cyc_data, next_cyc_data;
   logic wr_pend, next_wr_pend, rd_pend, next_rd_pend;
   logic [7:0] ph_ofs, next_ph_ofs;
   logic hready, next_hready;
   logic [31:0] hrdata, next_hrdata;
   logic pwr_n, next_pwr_n;
   logic cyc_done;
   logic [15:0] cyc_rdata;
   logic cmd_go, op_allowed;
   flc_pkg::flc_op_t wr_op;
   logic [31:0] status_word;

   flc_bus_cycle u_cycle (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .start_in(cyc_start),
      .write_in(cyc_write),
      .addr_in(cyc_addr),
      .data_in(cyc_data),
      .dq_in(dq_in),
      .done_out(cyc_done),
      .rdata_out(cyc_rdata),
      .pins_out(flash_out)
   );

   assign wr_op = flc_pkg::flc_op_t'(hwdata_in[flc_pkg::CMD_OP_LSB +: 4]);
   assign cmd_go = wr_pend && ph_ofs == flc_pkg::OFS_CMD;
   // A suspended program leaves only reads, mode selects and resume legal.
   assign op_allowed = reg_ctrl && state == S_IDLE && !(wr_op inside {flc_pkg::OP_BAD_E,
      flc_pkg::OP_BAD_F}) && (!psusp || wr_op inside {flc_pkg::OP_READ, flc_pkg::OP_ARRAY,
      flc_pkg::OP_STATUS, flc_pkg::OP_IDENT, flc_pkg::OP_QUERY, flc_pkg::OP_RESUME}); // R23
   assign status_word = {25'h0, !reg_ctrl, esusp, psusp, mode, refused, state != S_IDLE};

   always_comb begin
      next_state = state;
      next_cur_op = cur_op;
      next_mode = mode;
      next_reg_addr = reg_addr;
      next_reg_data = reg_data;
      next_reg_ctrl = reg_ctrl;
      next_refused = refused;
      next_psusp = psusp;
      next_esusp = esusp;
      next_job_prog = job_prog;
      next_cyc_start = 1'b0;
      next_cyc_write = cyc_write;
      next_cyc_addr = cyc_addr;
      next_cyc_data = cyc_data;
      next_hready = 1'b1;
      next_hrdata = hrdata;
      next_pwr_n = reg_ctrl;
      // Address phase: writes land next cycle, reads add one wait state.
      next_wr_pend = hsel_in && htrans_in[1] && hready_in && hwrite_in;
      next_rd_pend = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
      next_ph_ofs = (hsel_in && htrans_in[1] && hready_in) ? haddr_in[7:0] : ph_ofs;
      if (next_rd_pend) begin
         next_hready = 1'b0;
      end
      if (rd_pend) begin
         unique case (ph_ofs)
            flc_pkg::OFS_ADDR: next_hrdata = 32'(reg_addr);
            flc_pkg::OFS_DATA: next_hrdata = {16'h0000, reg_data};
            flc_pkg::OFS_RDATA: next_hrdata = {16'h0000, cyc_rdata};
            flc_pkg::OFS_STATUS: next_hrdata = status_word;
            flc_pkg::OFS_CTRL: next_hrdata = {31'h0, reg_ctrl};
            default: next_hrdata = 32'h0000_0000;
         endcase
      end
      if (wr_pend) begin
         unique case (ph_ofs)
            flc_pkg::OFS_ADDR: next_reg_addr = hwdata_in[flc_pkg::ADDR_W-1:0];
            flc_pkg::OFS_DATA: next_reg_data = hwdata_in[15:0];
            flc_pkg::OFS_CTRL: next_reg_ctrl = hwdata_in[0];
            flc_pkg::OFS_STATUS: begin
               if (hwdata_in[flc_pkg::ST_REFUSED]) begin
                  next_refused = 1'b0;
               end
            end
            default: next_reg_ctrl = reg_ctrl;
         endcase
      end
      if (cmd_go && op_allowed) begin
         next_cur_op = wr_op;
         next_cyc_start = 1'b1;
         next_cyc_write = wr_op != flc_pkg::OP_READ;
         next_cyc_addr = reg_addr;
         // Only the low byte carries the code; the high byte is held at zero.
         next_cyc_data = {8'h00, first_code(wr_op, hwdata_in[flc_pkg::CMD_ALT_BIT])}; // R25
         next_state = S_FIRST;
      end else if (cmd_go) begin
         next_refused = 1'b1; // R23
      end
      unique case (state)
         S_IDLE: next_state = next_state;
         S_FIRST: begin
            if (cyc_done && two_cycle(cur_op)) begin
               next_cyc_start = 1'b1;
               next_cyc_write = 1'b1;
               next_cyc_addr = reg_addr; // R24
               next_cyc_data = second_word(cur_op, reg_data); // R2
               next_state = S_SECOND;
            end else if (cyc_done) begin
               next_state = S_IDLE;
               unique case (cur_op)
                  flc_pkg::OP_ARRAY: next_mode = flc_pkg::MODE_ARRAY; // R1
                  flc_pkg::OP_IDENT: next_mode = flc_pkg::MODE_IDENT;
                  flc_pkg::OP_QUERY: next_mode = flc_pkg::MODE_QUERY;
                  flc_pkg::OP_STATUS: next_mode = flc_pkg::MODE_STATUS;
                  flc_pkg::OP_SUSPEND: begin
                     next_mode = flc_pkg::MODE_STATUS;
                     next_psusp = job_prog || psusp;
                     next_esusp = !job_prog || esusp;
                  end
                  flc_pkg::OP_RESUME: begin
                     // A nested program resumes before the erase that holds it.
                     next_mode = flc_pkg::MODE_STATUS;
                     next_psusp = 1'b0;
                     next_esusp = psusp && esusp;
                     next_job_prog = psusp;
                  end
                  default: next_mode = mode;
               endcase
            end
         end
         S_SECOND: begin
            if (cyc_done) begin
               next_state = S_IDLE;
               if (cur_op inside {flc_pkg::OP_PROGRAM, flc_pkg::OP_PROT,
                                  flc_pkg::OP_ERASE}) begin
                  // The device shows status after a job starts until array read.
                  next_mode = flc_pkg::MODE_STATUS; // R4
                  next_job_prog = cur_op != flc_pkg::OP_ERASE; // R21
               end
            end
         end
         default: next_state = S_IDLE;
      endcase
      // Holding the pin low aborts everything, so the device wakes in array mode.
      if (!reg_ctrl) begin
         next_mode = flc_pkg::MODE_ARRAY; // R11
         next_psusp = 1'b0;
         next_esusp = 1'b0;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state <= S_IDLE;
         cur_op <= flc_pkg::OP_READ;
         mode <= flc_pkg::MODE_ARRAY;
         reg_addr <= '0;
         reg_data <= 16'h0000;
         reg_ctrl <= flc_pkg::CTRL_RESET;
         refused <= 1'b0;
         psusp <= 1'b0;
         esusp <= 1'b0;
         job_prog <= 1'b0;
         cyc_start <= 1'b0;
         cyc_write <= 1'b0;
         cyc_addr <= '0;
         cyc_data <= 16'h0000;
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         ph_ofs <= 8'h00;
         hready <= 1'b1;
         hrdata <= 32'h0000_0000;
         pwr_n <= 1'b0;
      end else begin
         state <= next_state;
         cur_op <= next_cur_op;
         mode <= next_mode;
         reg_addr <= next_reg_addr;
         reg_data <= next_reg_data;
         reg_ctrl <= next_reg_ctrl;
         refused <= next_refused;
         psusp <= next_psusp;
         esusp <= next_esusp;
         job_prog <= next_job_prog;
         cyc_start <= next_cyc_start;
         cyc_write <= next_cyc_write;
         cyc_addr <= next_cyc_addr;
         cyc_data <= next_cyc_data;
         wr_pend <= next_wr_pend;
         rd_pend <= next_rd_pend;
         ph_ofs <= next_ph_ofs;
         hready <= next_hready;
         hrdata <= next_hrdata;
         pwr_n <= next_pwr_n;
      end
   end

   assign hreadyout_out = hready;
   assign hresp_out = 1'b0;
   assign hrdata_out = hrdata;
   assign reset_powerdown_n_out = pwr_n;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   sequence cmd_taken(flc_pkg::flc_op_t op);
      cmd_go && op_allowed && wr_op == op;
   endsequence
   sequence second_due(flc_pkg::flc_op_t op);
      state == S_FIRST && cyc_done && cur_op == op;
   endsequence

   a_array_code: assert property (cmd_taken(flc_pkg::OP_ARRAY) |=>
      cyc_start && cyc_write && cyc_data == {8'h00, flc_pkg::CODE_ARRAY}) // R1
      else $error("Array-read op did not send code FF.");
   a_prog_first_code: assert property (cmd_taken(flc_pkg::OP_PROGRAM) |=> cyc_start &&
      cyc_data[7:0] == ($past(hwdata_in[4]) ? 8'h10 : 8'h40)) // R3
      else $error("Program first write code wrong.");
   a_prog_second: assert property (second_due(flc_pkg::OP_PROGRAM) |=>
      cyc_start && cyc_write && cyc_data == reg_data && cyc_addr == reg_addr) // R2
      else $error("Program second write lacks address or data.");
   a_erase_confirm: assert property (second_due(flc_pkg::OP_ERASE) |=>
      cyc_start && cyc_data == 16'h00d0 && cyc_addr == reg_addr) // R24
      else $error("Erase confirm not D0 at block address.");
   a_prog_status: assert property (state == S_SECOND && cyc_done &&
      cur_op == flc_pkg::OP_PROGRAM |=> mode == flc_pkg::MODE_STATUS && state == S_IDLE) // R4
      else $error("Mode not status after program started.");
   a_clear_code: assert property (cmd_taken(flc_pkg::OP_CLEAR) |=>
      cyc_data == 16'h0050 ##1 !cyc_start [*2]) // R15
      else $error("Clear op did not send code 50 once.");
   a_prot_seq: assert property (cmd_taken(flc_pkg::OP_PROT) |=> cyc_data == 16'h00c0
      ##[1:20] (state == S_SECOND && cyc_data == reg_data)) // R21
      else $error("Protection program sequence wrong.");
   a_susp_refuse: assert property (psusp && cmd_go && wr_op == flc_pkg::OP_ERASE |=>
      !cyc_start && refused) // R23
      else $error("Command sent while program suspended.");
endmodule : flc_host

// ---- pkg/flc_pkg.sv ----
// Purpose: Shared constants and types of the flash command host controller.
// Assumes: A 40 MHz system clock and a x16 flash part with 22 word-address bits.
// Notes: Register offsets are byte addresses on the AHB-Lite slave port.
package flc_pkg;
   localparam int ADDR_W = 22;
   localparam int DQ_W = 16;
   // Register map, byte offsets in the low address byte.
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_RDATA = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_CTRL = 8'h14;
   // Fields of the command register.
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_ALT_BIT = 4;
   // Fields of the status register.
   localparam int ST_BUSY = 0;
   localparam int ST_REFUSED = 1;
   localparam int ST_MODE_LSB = 2;
   localparam int ST_PSUSP = 4;
   localparam int ST_ESUSP = 5;
   localparam int ST_PWRDN = 6;
   localparam logic CTRL_RESET = 1'b0;
   // Command codes placed on the low data byte.
   localparam logic [7:0] CODE_ARRAY = 8'hff;
   localparam logic [7:0] CODE_PROG = 8'h40;
   localparam logic [7:0] CODE_PROG_ALT = 8'h10;
   localparam logic [7:0] CODE_ERASE = 8'h20;
   localparam logic [7:0] CODE_CONFIRM = 8'hd0;
   localparam logic [7:0] CODE_SUSPEND = 8'hb0;
   localparam logic [7:0] CODE_STATUS = 8'h70;
   localparam logic [7:0] CODE_CLEAR = 8'h50;
   localparam logic [7:0] CODE_IDENT = 8'h90;
   localparam logic [7:0] CODE_LOCK_SETUP = 8'h60;
   localparam logic [7:0] CODE_LOCK = 8'h01;
   localparam logic [7:0] CODE_LOCKDOWN = 8'h2f;
   localparam logic [7:0] CODE_QUERY = 8'h98;
   localparam logic [7:0] CODE_PROT = 8'hc0;
   // Pin timing.
   localparam int CLK_NS = 25;
   localparam int WP_NS = 50;
   localparam int ACC_NS = 70;
   localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_CYC = 2;
   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_ARRAY = 4'h1, OP_STATUS = 4'h2, OP_IDENT = 4'h3,
      OP_QUERY = 4'h4, OP_CLEAR = 4'h5, OP_PROGRAM = 4'h6, OP_ERASE = 4'h7,
      OP_SUSPEND = 4'h8, OP_RESUME = 4'h9, OP_LOCK = 4'ha, OP_UNLOCK = 4'hb,
      OP_LOCKDOWN = 4'hc, OP_PROT = 4'hd, OP_BAD_E = 4'he, OP_BAD_F = 4'hf
   } flc_op_t;
   typedef enum logic [1:0] {
      MODE_ARRAY = 2'b00, MODE_STATUS = 2'b01, MODE_IDENT = 2'b10, MODE_QUERY = 2'b11
   } flc_mode_t;
   typedef struct packed {
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic dq_oe;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0] dq;
   } flc_pins_t;
endpackage : flc_pkg

// ---- hw/flc_bus_cycle.sv ----
// Purpose: Runs one write or read cycle on the flash pins.
// Assumes: Start arrives only while the cycle engine is idle.
// Notes: Read data passes two flip-flops before it is captured.
`timescale 1ns/1ps
module flc_bus_cycle (
   input wire logic clock_in, // System clock.
   input wire logic rst_in, // Asynchronous reset, active high.
   input wire logic start_in, // One-cycle start pulse.
   input wire logic write_in, // High for a write cycle.
   input wire logic [flc_pkg::ADDR_W-1:0] addr_in, // Cycle address.
   input wire logic [flc_pkg::DQ_W-1:0] data_in, // Write data.
   input wire logic [flc_pkg::DQ_W-1:0] dq_in, // Data pins as seen on the board.
   output logic done_out, // One-cycle pulse at cycle end.
   output logic [flc_pkg::DQ_W-1:0] rdata_out, // Last word read.
   output flc_pkg::flc_pins_t pins_out // Flash pin drive.
);
   typedef enum logic [2:0] {
      C_IDLE = 3'b000, C_SETUP = 3'b001, C_STROBE = 3'b010,
      C_HOLD = 3'b011, C_SYNC = 3'b100, C_RECOV = 3'b101
   } flc_cyc_t;
   flc_cyc_t state, next_state;
   logic [3:0] cnt, next_cnt;
   logic wr, next_wr;
   logic done, next_done;
   logic [flc_pkg::DQ_W-1:0] rdata, next_rdata, dq_s1, dq_s2;
   flc_pkg::flc_pins_t pins, next_pins;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_wr = wr;
      next_done = 1'b0;
      next_rdata = rdata;
      next_pins = pins;
      unique case (state)
         C_IDLE: begin
            if (start_in) begin
               next_pins.ce_n = 1'b0;
               next_pins.addr = addr_in;
               next_pins.dq = data_in;
               next_pins.dq_oe = write_in;
               next_wr = write_in;
               next_state = C_SETUP;
            end
         end
         C_SETUP: begin
            if (wr) begin
               next_pins.we_n = 1'b0;
               next_cnt = 4'(flc_pkg::WP_CYC - 1);
            end else begin
               next_pins.oe_n = 1'b0;
               next_cnt = 4'(flc_pkg::ACC_CYC - 1);
            end
            next_state = C_STROBE;
         end
         C_STROBE: begin
            if (cnt != 4'h0) begin
               next_cnt = cnt - 4'h1;
            end else if (wr) begin
               // The device takes the command on this rising write strobe.
               next_pins.we_n = 1'b1; // R25
               next_state = C_HOLD;
            end else begin
               next_cnt = 4'(flc_pkg::SYNC_CYC - 1);
               next_state = C_SYNC;
            end
         end
         C_HOLD: begin
            next_pins.ce_n = 1'b1;
            next_pins.dq_oe = 1'b0;
            next_state = C_RECOV;
         end
         C_SYNC: begin
            if (cnt != 4'h0) begin
               next_cnt = cnt - 4'h1;
            end else begin
               next_rdata = dq_s2;
               next_pins.oe_n = 1'b1;
               next_pins.ce_n = 1'b1;
               next_state = C_RECOV;
            end
         end
         C_RECOV: begin
            next_done = 1'b1;
            next_state = C_IDLE;
         end
         default: next_state = C_IDLE;
      endcase
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state <= C_IDLE;
         cnt <= 4'h0;
         wr <= 1'b0;
         done <= 1'b0;
         rdata <= 16'h0000;
         dq_s1 <= 16'h0000;
         dq_s2 <= 16'h0000;
         pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe: 1'b0,
                   addr: '0, dq: 16'h0000};
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         wr <= next_wr;
         done <= next_done;
         rdata <= next_rdata;
         dq_s1 <= dq_in;
         dq_s2 <= dq_s1;
         pins <= next_pins;
      end
   end

   assign done_out = done;
   assign rdata_out = rdata;
   assign pins_out = pins;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   sequence we_low_pulse;
      !pins.we_n [*2] ##1 (pins.we_n && !pins.ce_n && pins.dq_oe);
   endsequence
   a_we_strobe_width: assert property ($fell(pins.we_n) |-> we_low_pulse) // R25
      else $error("Write strobe width or chip enable wrong at rising edge.");
   a_cycle_ends: assert property (start_in && state == C_IDLE |-> ##[4:12] done) // R25
      else $error("Pin cycle did not complete in time.");
   a_we_oe_apart: assert property (!(!pins.we_n && !pins.oe_n))
      else $error("Write and output enables low together.");
endmodule : flc_bus_cycle

// ---- bench/flc_flash_model.sv ----
// Purpose: Behavioural flash part that logs command writes and answers reads.
// Assumes: Writes latch on the rising write strobe while chip enable is low.
// Notes: A released data bus shows the inverse of the current read value, not a held value.
`timescale 1ns/1ps
module flc_flash_model (
   input wire logic ce_n_in, // Chip enable, active low.
   input wire logic we_n_in, // Write strobe, active low.
   input wire logic oe_n_in, // Output enable, active low.
   input wire logic rp_n_in, // Reset/power-down, active low.
   input wire logic [21:0] addr_in, // Address pins.
   input wire logic [15:0] dq_in, // Resolved data wire.
   output logic [15:0] dq_out // Read drive.
);
   logic [7:0] prev_code;
   logic [7:0] last_code;
   logic [21:0] last_addr;
   logic [15:0] last_data;
   logic status_mode;
   logic seq_err;
   logic [15:0] rd_val;
   always @(posedge we_n_in or negedge rp_n_in) begin
      if (!rp_n_in) begin
         status_mode <= 1'b0;
         seq_err <= 1'b0;
         prev_code <= 8'h00;
         last_code <= 8'h00;
      end else if (!ce_n_in) begin
         prev_code <= last_code;
         last_code <= dq_in[7:0];
         last_addr <= addr_in;
         last_data <= dq_in;
         if (dq_in[7:0] == 8'hff) begin
            status_mode <= 1'b0;
         end else if (dq_in[7:0] == 8'h70) begin
            status_mode <= 1'b1;
         end else if (last_code inside {8'h40, 8'h10, 8'h20, 8'hc0}) begin
            status_mode <= 1'b1;
         end
         // A bad second write sets both error flags; code 50 or a low rp_n_in clears them.
         if ((last_code == 8'h20 && dq_in[7:0] != 8'hd0) ||
             (last_code == 8'h60 && !(dq_in[7:0] inside {8'h01, 8'hd0, 8'h2f}))) begin
            seq_err <= 1'b1;
         end else if (dq_in[7:0] == 8'h50) begin
            seq_err <= 1'b0;
         end
      end
   end
   assign rd_val = status_mode ? (16'h0080 | {10'h000, seq_err, seq_err, 4'h0}) :
      ~addr_in[15:0];
   assign dq_out = (!ce_n_in && !oe_n_in) ? rd_val : ~rd_val;
endmodule : flc_flash_model

// ---- bench/testbench.sv ----
// Purpose: Drives command sequences through the register port and checks the pins.
// Assumes: The flash model logs every latched command write.
// Notes: Busy is polled between commands so no request is refused by accident.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
   logic clock_in = 1'b0, rst_in = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready_out, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic [1:0] htrans = 2'b00;
   logic [15:0] dq, mdq;
   logic rp_n;
   flc_pkg::flc_pins_t fl;
   int n_fail = 0, samples_checked = 0, cyc = 0;
   logic [4:0] ops [14] = '{5'h1, 5'h2, 5'h3, 5'h4, 5'h5, 5'h6, 5'h16, 5'h7, 5'h8, 5'h9,
      5'ha, 5'hb, 5'hc, 5'hd};
   logic [15:0] exp [14] = '{16'h00ff, 16'h0070, 16'h0090, 16'h0098, 16'h0050, 16'h40a5,
      16'h10a5, 16'h20d0, 16'h00b0, 16'h00d0, 16'h6001, 16'h60d0, 16'h602f, 16'hc0a5};
   always #12.5 clock_in = ~clock_in;
   assign dq = fl.dq_oe ? fl.dq : mdq;
   flc_host dut (.clock_in(clock_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hready_out), .dq_in(dq), .hreadyout_out(hready_out), .hresp_out(hresp),
      .hrdata_out(hrdata), .flash_out(fl), .reset_powerdown_n_out(rp_n));
   flc_flash_model model (.ce_n_in(fl.ce_n), .we_n_in(fl.we_n), .oe_n_in(fl.oe_n),
      .rp_n_in(rp_n), .addr_in(fl.addr), .dq_in(dq), .dq_out(mdq));
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge clock_in);
      while (hready_out !== 1'b1) @(posedge clock_in);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clock_in);
      while (hready_out !== 1'b1) @(posedge clock_in);
      r = hrdata;
      `CHK(hresp, 1'b0)
   endtask : ahb
   task automatic cmd(input logic [4:0] op);
      ahb(1'b1, flc_pkg::OFS_CMD, {27'h0, op});
      repeat (40) begin
         ahb(1'b0, flc_pkg::OFS_STATUS, 32'h0);
         if (r[flc_pkg::ST_BUSY] === 1'b0) break;
      end
   endtask : cmd
   initial begin
      repeat (3) @(posedge clock_in);
      rst_in <= 1'b0;
      `CHK(rp_n, 1'b0)
      ahb(1'b1, flc_pkg::OFS_CTRL, 32'h1);
      ahb(1'b1, flc_pkg::OFS_ADDR, 32'h12345);
      `CHK(rp_n, 1'b1)
      ahb(1'b0, flc_pkg::OFS_ADDR, 32'h0);
      `CHK(r, 32'h12345)
      ahb(1'b1, flc_pkg::OFS_DATA, 32'h5aa5);
      repeat (4) @(posedge clock_in);
      for (int i = 0; i < 14; i++) begin
         cmd(ops[i]);
         `CHK(model.last_code, exp[i][7:0])
         if (exp[i][15:8] != 8'h00) `CHK(model.prev_code, exp[i][15:8])
         if (ops[i] == 5'h6) `CHK(model.last_data, 16'h5aa5)
      end
      `CHK(model.last_addr, 22'h12345)
      cmd(5'h0);
      ahb(1'b0, flc_pkg::OFS_RDATA, 32'h0);
      `CHK(r[15:0], 16'h0080)
      cmd(5'h6);
      cmd(5'h8);
      `CHK(r[flc_pkg::ST_PSUSP], 1'b1)
      cmd(5'h7);
      `CHK(r[flc_pkg::ST_REFUSED], 1'b1)
      `CHK(model.last_code, 8'hb0)
      ahb(1'b1, flc_pkg::OFS_STATUS, 32'h2);
      cmd(5'h9);
      `CHK(r[flc_pkg::ST_PSUSP], 1'b0)
      cmd(5'h1);
      `CHK(r[3:2], 2'b00)
      `CHK(r[flc_pkg::ST_REFUSED], 1'b0)
      cmd(5'h0);
      ahb(1'b0, flc_pkg::OFS_RDATA, 32'h0);
      `CHK(r[15:0], 16'hdcba)
      cmd(5'he);
      `CHK(r[flc_pkg::ST_REFUSED], 1'b1)
      `CHK(model.last_code, 8'hff)
      test_done();
   end
endmodule : testbench
